/* File: logic/irq_pkg.sv */
// Constants shared by the interrupt handler files
package irq_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int          NUM_SRC     = 15;
	localparam int          IDX_W       = 4;
	localparam int          ADR_W       = 8;
	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0]  ADR_IE      = 8'hA8;
	localparam logic [7:0]  ADR_IP      = 8'hAC;
	localparam logic [7:0]  ADR_EIE     = 8'hB0;
	localparam logic [7:0]  ADR_EIP     = 8'hB4;
	localparam logic [7:0]  ADR_PEND    = 8'hB8;
	localparam logic [7:0]  ADR_STAT    = 8'hBC;
	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int          GLOBAL_BIT  = 7;
	localparam logic [7:0]  IE_RST      = 8'h00;
	localparam logic [7:0]  IP_RST      = 8'h00;
	localparam logic [7:0]  IP_RD_ONES  = 8'h80;
	localparam logic [7:0]  IP_WR_MASK  = 8'h7F;
	localparam logic [7:0]  EIE_RST     = 8'h00;
	localparam logic [7:0]  EIP_RST     = 8'h00;
	localparam logic [7:0]  EXT_WR_MASK = 8'hB9;
	localparam logic [14:0] SRC_VALID   = 15'h5CFF;
	localparam logic [14:0] SRC_HWCLR   = 15'h000F;
	localparam logic [14:0] PEND_RST    = 15'h0000;
	// ****************************************
	// Vectors
	// ****************************************
	localparam logic [15:0] VEC_RESET   = 16'h0000;
	localparam logic [15:0] VEC_BASE    = 16'h0003;
	localparam logic [15:0] VEC_LAST    = 16'h0073;
endpackage

/* File: logic/irq_sel_if.sv */
// Request vector and winner index between handler and encoder
interface irq_sel_if #(parameter int N = 15, parameter int IW = 4);
	logic [N-1:0]  req;
	logic          found;
	logic [IW-1:0] idx;
	modport enc  (input req, output found, output idx);
	modport user (output req, input found, input idx);
endinterface

/* File: logic/irq_prio_enc.sv */
// Fixed order encoder: lowest set index wins
module irq_prio_enc #(
	parameter int N  = 15,
	parameter int IW = 4
) (
	irq_sel_if.enc sel
);
	always_comb
	begin
		sel.found = 1'b0;
		sel.idx   = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (sel.req[i])
			begin
				sel.found = 1'b1;
				sel.idx   = IW'(i);
			end
		end
	end
endmodule

/* File: logic/irq_handler.sv */
// Two-level vectored interrupt handler with Wishbone registers
//
// The Wishbone slave port is this design's own decision.
module irq_handler
	import irq_pkg::*;
#(
	parameter int N = NUM_SRC
) (
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [N-1:0]      src_event_i,
	input  wire logic              irq_ack_i,
	input  wire logic              return_from_irq_instr_i,
	input  wire logic              instr_done_i,
	output logic                   irq_req_o,
	output logic      [15:0]       irq_vector_o,
	output logic                   irq_level_o
);
	// ****************************************
	// State
	// ****************************************
	logic [7:0]       ie_r;
	logic [7:0]       ip_r;
	logic [7:0]       eie_r;
	logic [7:0]       eip_r;
	logic [N-1:0]     pend_r;
	logic [N-1:0]     pend_nxt;
	logic             act_hi_r;
	logic             act_lo_r;
	logic             hold_r;
	logic [IDX_W-1:0] idx_r;
	logic [31:0]      rdat_nxt;
	logic             req_nxt;
	logic [15:0]      vec_nxt;

	// ****************************************
	// Bus decode
	// ****************************************
	wire              bus_req  = wb_cyc_i & wb_stb_i;
	wire              bus_fire = bus_req & wb_ack_o;
	wire              wr_fire  = bus_fire & wb_we_i;
	wire              lane0    = wb_sel_i[0];
	wire              lane1    = wb_sel_i[1];
	wire              hit_ie   = wb_adr_i == ADR_IE;
	wire              hit_ip   = wb_adr_i == ADR_IP;
	wire              hit_eie  = wb_adr_i == ADR_EIE;
	wire              hit_eip  = wb_adr_i == ADR_EIP;
	wire              hit_pend = wb_adr_i == ADR_PEND;
	wire              hit_stat = wb_adr_i == ADR_STAT;
	wire              wr_ie    = wr_fire & lane0 & hit_ie;
	wire              wr_ip    = wr_fire & lane0 & hit_ip;
	wire              wr_eie   = wr_fire & lane0 & hit_eie;
	wire              wr_eip   = wr_fire & lane0 & hit_eip;
	wire              wr_pend  = wr_fire & hit_pend;
	wire [N-1:0]      lane_msk = N'({{8{lane1}}, {8{lane0}}});
	wire [N-1:0]      wr_val   = N'(wb_dat_i[15:0]);

	always_comb
	begin
		rdat_nxt = 32'h0000_0000;
		if (hit_ie)
			rdat_nxt[7:0] = ie_r;
		else if (hit_ip)
			rdat_nxt[7:0] = ip_r | IP_RD_ONES;
		else if (hit_eie)
			rdat_nxt[7:0] = eie_r;
		else if (hit_eip)
			rdat_nxt[7:0] = eip_r;
		else if (hit_pend)
			rdat_nxt[N-1:0] = pend_r;
		else if (hit_stat)
			rdat_nxt[7:0] = {hold_r, act_lo_r, act_hi_r, irq_req_o, idx_r};
	end

	// Single wait state; unmapped addresses answer zero
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			wb_dat_o <= rdat_nxt;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ie_r  <= IE_RST;
			ip_r  <= IP_RST;
			eie_r <= EIE_RST;
			eip_r <= EIP_RST;
		end
		else
		begin
			if (wr_ie)
				ie_r <= wb_dat_i[7:0];
			if (wr_ip)
				ip_r <= wb_dat_i[7:0] & IP_WR_MASK;
			if (wr_eie)
				eie_r <= wb_dat_i[7:0] & EXT_WR_MASK;
			if (wr_eip)
				eip_r <= wb_dat_i[7:0] & EXT_WR_MASK;
		end
	end

	// ****************************************
	// Per-source enable and priority maps
	// ****************************************
	wire          global_en = ie_r[GLOBAL_BIT];
	wire [N-1:0]  en_src    = {eie_r[7], 1'b0, eie_r[5:3], 2'b00,
	                           eie_r[0], ie_r[6:0]};
	wire [N-1:0]  pr_src    = {eip_r[7], 1'b0, eip_r[5:3], 2'b00,
	                           eip_r[0], ip_r[6:0]};

	// ****************************************
	// Pending flags
	// ****************************************
	// Set beats clear so an event never drops in a clear cycle
	wire          vec_take = irq_ack_i & irq_req_o;
	wire [N-1:0]  ack_oh   = N'(1) << idx_r;
	wire [N-1:0]  hw_clr   = vec_take ? (ack_oh & SRC_HWCLR) : '0;
	wire [N-1:0]  sw_clr   = wr_pend ? (lane_msk & ~wr_val) : '0;
	wire [N-1:0]  sw_set   = wr_pend ? (lane_msk & wr_val) : '0;
	wire [N-1:0]  set_all  = (src_event_i | sw_set) & SRC_VALID;

	assign pend_nxt = (pend_r & ~(hw_clr | sw_clr)) | set_all;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			pend_r <= PEND_RST;
		else
			pend_r <= pend_nxt;
	end

	// ****************************************
	// Arbitration
	// ****************************************
	irq_sel_if #(.N(N), .IW(IDX_W)) hi_sel ();
	irq_sel_if #(.N(N), .IW(IDX_W)) lo_sel ();

	// Flags stay set while masked; only the request is gated
	wire [N-1:0]  elig = pend_r & en_src & {N{global_en}};
	assign hi_sel.req = elig & pr_src;
	assign lo_sel.req = elig & ~pr_src;

	irq_prio_enc #(.N(N), .IW(IDX_W)) u_hi_enc (.sel(hi_sel));
	irq_prio_enc #(.N(N), .IW(IDX_W)) u_lo_enc (.sel(lo_sel));

	// High routine blocks all; low routine blocks low
	wire          hi_ok    = hi_sel.found & ~act_hi_r;
	wire          lo_ok    = lo_sel.found & ~act_hi_r & ~act_lo_r;
	wire          blocked  = hold_r | return_from_irq_instr_i | vec_take;
	wire          win_hi   = hi_ok;
	wire [IDX_W-1:0] win_idx = win_hi ? hi_sel.idx : lo_sel.idx;

	assign req_nxt = (hi_ok | lo_ok) & ~blocked;
	assign vec_nxt = VEC_BASE + {9'h000, win_idx, 3'b000};

	// ****************************************
	// Core handshake
	// ****************************************
	// Request follows one detect cycle; core adds the call cycles
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			irq_req_o    <= 1'b0;
			irq_vector_o <= VEC_RESET;
			irq_level_o  <= 1'b0;
			idx_r        <= '0;
		end
		else
		begin
			irq_req_o <= req_nxt;
			if (req_nxt)
			begin
				irq_vector_o <= vec_nxt;
				irq_level_o  <= win_hi;
				idx_r        <= win_idx;
			end
		end
	end

	// Return frees the top level; hold lasts one instruction
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			act_hi_r <= 1'b0;
			act_lo_r <= 1'b0;
			hold_r   <= 1'b0;
		end
		else
		begin
			if (vec_take && irq_level_o)
				act_hi_r <= 1'b1;
			else if (return_from_irq_instr_i && act_hi_r)
				act_hi_r <= 1'b0;
			if (vec_take && !irq_level_o)
				act_lo_r <= 1'b1;
			else if (return_from_irq_instr_i && !act_hi_r)
				act_lo_r <= 1'b0;
			if (return_from_irq_instr_i)
				hold_r <= 1'b1;
			else if (instr_done_i)
				hold_r <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking

	sequence s_ret_quiet;
		!irq_req_o ##0 hold_r;
	endsequence

	property p_event_sets;
		disable iff (srst_i)
		(|(src_event_i & SRC_VALID)) |=>
			((pend_r & $past(src_event_i & SRC_VALID)) == $past(src_event_i & SRC_VALID));
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("event lost");

	property p_global_off;
		disable iff (srst_i)
		!global_en |=> !irq_req_o;
	endproperty
	a_global_off: assert property (p_global_off) else $error("request while off");

	property p_held;
		disable iff (srst_i)
		(!global_en && !wr_pend && !vec_take) |=> ((pend_r & $past(pend_r)) == $past(pend_r));
	endproperty
	a_held: assert property (p_held) else $error("pending flag dropped");

	property p_fast;
		disable iff (srst_i)
		((hi_ok || lo_ok) && !blocked) |=> irq_req_o;
	endproperty
	a_fast: assert property (p_fast) else $error("request late");

	property p_hw_clear;
		disable iff (srst_i)
		(vec_take && idx_r < 4'h4 && !src_event_i[idx_r] && !wr_pend) |=> !pend_r[$past(idx_r)];
	endproperty
	a_hw_clear: assert property (p_hw_clear) else $error("flag not cleared");

	property p_soft_set;
		disable iff (srst_i)
		(wr_pend && lane0 && wb_dat_i[0]) |=> pend_r[0];
	endproperty
	a_soft_set: assert property (p_soft_set) else $error("soft set ignored");

	property p_no_preempt;
		disable iff (srst_i)
		act_hi_r |=> !irq_req_o;
	endproperty
	a_no_preempt: assert property (p_no_preempt) else $error("high preempted");

	property p_reset_low;
		disable iff (srst_i)
		$fell(srst_i) |-> (ip_r == IP_RST && eip_r == EIP_RST);
	endproperty
	a_reset_low: assert property (p_reset_low) else $error("priority not low");

	property p_hi_first;
		disable iff (srst_i)
		(hi_ok && !blocked) |=> (irq_req_o && irq_level_o);
	endproperty
	a_hi_first: assert property (p_hi_first) else $error("low served first");

	property p_vector;
		disable iff (srst_i)
		irq_req_o |-> (irq_vector_o[2:0] == 3'h3 && irq_vector_o <= VEC_LAST);
	endproperty
	a_vector: assert property (p_vector) else $error("bad vector");

	property p_return_from_irq_instr_hold;
		disable iff (srst_i)
		return_from_irq_instr_i |=> s_ret_quiet;
	endproperty
	a_return_from_irq_instr_hold: assert property (p_return_from_irq_instr_hold) else $error("no hold after return");

	property p_hold_wait;
		disable iff (srst_i)
		(hold_r && !instr_done_i) |=> !irq_req_o;
	endproperty
	a_hold_wait: assert property (p_hold_wait) else $error("call before instruction");

	property p_ack_drop;
		disable iff (srst_i)
		vec_take |=> !irq_req_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");

	property p_level_latch;
		disable iff (srst_i)
		vec_take |=> (act_hi_r || act_lo_r);
	endproperty
	a_level_latch: assert property (p_level_latch) else $error("level not latched");

	property p_masked_quiet;
		disable iff (srst_i)
		(elig == '0) |=> !irq_req_o;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("masked request");

	property p_low_wait;
		disable iff (srst_i)
		(act_lo_r && !hi_sel.found) |=> !irq_req_o;
	endproperty
	a_low_wait: assert property (p_low_wait) else $error("low preempted by low");
endmodule

/* File: dv/irq_core_model.sv */
// Behavioural CPU core taking interrupt requests
module irq_core_model (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic irq_req_i,
	input  wire logic slow_i,
	output logic      irq_ack_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_r;
	// ****************************************
	// Ack at an instruction boundary
	// ****************************************
	// Slow mode makes the request stand for several cycles
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			irq_ack_o <= 1'b0;
			wait_r    <= 2'h0;
		end
		else if (irq_ack_o)
			irq_ack_o <= 1'b0;
		else if (irq_req_i)
		begin
			if (!slow_i || wait_r == 2'h3)
			begin
				irq_ack_o <= 1'b1;
				wait_r    <= 2'h0;
			end
			else
				wait_r <= wait_r + 2'h1;
		end
	end
endmodule

/* File: dv/two_level_vectored_interrupt_handler_tb.sv */
// Self-checking bench for the interrupt handler
module two_level_vectored_interrupt_handler_tb;
	import irq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i      = 1'b0;
	logic        srst_i     = 1'b1;
	logic        cyc        = 1'b0;
	logic        stb        = 1'b0;
	logic        we         = 1'b0;
	logic        return_from_irq_instr       = 1'b0;
	logic        idone      = 1'b0;
	logic        slow       = 1'b0;
	logic [7:0]  adr        = 8'h00;
	logic [3:0]  sel        = 4'h0;
	logic [31:0] dat        = 32'h0000_0000;
	logic [14:0] src        = 15'h0000;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        wbk;
	logic        ack;
	logic        req;
	logic        lvl;
	logic        lvl_q;
	logic [15:0] vec;
	logic [15:0] vec_q;
	int          checked    = 0;
	int          fail_count = 0;
	int          acks       = 0;
	// ****************************************
	// Design, core and monitor
	// ****************************************
	irq_handler i_dut (
		.clk_i        (clk_i),
		.srst_i       (srst_i),
		.wb_cyc_i     (cyc),
		.wb_stb_i     (stb),
		.wb_we_i      (we),
		.wb_adr_i     (adr),
		.wb_sel_i     (sel),
		.wb_dat_i     (dat),
		.wb_dat_o     (rdat),
		.wb_ack_o     (wbk),
		.src_event_i  (src),
		.irq_ack_i    (ack),
		.return_from_irq_instr_i       (return_from_irq_instr),
		.instr_done_i (idone),
		.irq_req_o    (req),
		.irq_vector_o (vec),
		.irq_level_o  (lvl)
	);
	irq_core_model i_core (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.irq_req_i (req),
		.slow_i    (slow),
		.irq_ack_o (ack)
	);
	initial
	begin
		forever
			#5 clk_i = ~clk_i;
	end
	// Latch what the core accepted, at the accepting edge
	always @(posedge clk_i)
	begin
		if (ack && req)
		begin
			acks  <= acks + 1;
			vec_q <= vec;
			lvl_q <= lvl;
		end
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// No cycle limit here; the watchdog ends a hung access
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		@(posedge clk_i);
		while (wbk !== 1'b1)
			@(posedge clk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic ev(input logic [14:0] m);
		src <= m;
		@(posedge clk_i);
		src <= 15'h0000;
	endtask
	task automatic quiet(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			chk(32'h0000_0000, {31'h0, req});
		end
	endtask
	// A missing acceptance is a mismatch, never a silent pass
	task automatic take(input logic [15:0] v, input logic l);
		int s;
		int n;
		s = acks;
		n = 0;
		while (acks == s && n < 60)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(s + 1), 32'(acks));
		chk({16'h0000, v}, {16'h0000, vec_q});
		chk({31'h0, l}, {31'h0, lvl_q});
	endtask
	task automatic ret();
		return_from_irq_instr  <= 1'b1;
		@(posedge clk_i);
		return_from_irq_instr  <= 1'b0;
		idone <= 1'b1;
		@(posedge clk_i);
		idone <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		wb(1'b0, ADR_IE, 32'h0000_0000);
		chk(32'h0000_0000, q);
		wb(1'b0, ADR_IP, 32'h0000_0000);
		chk(32'h0000_0080, q);
		wb(1'b0, ADR_EIP, 32'h0000_0000);
		chk(32'h0000_0000, q);
		wb(1'b1, 8'hC0, 32'h0000_00FF);
		wb(1'b0, 8'hC0, 32'h0000_0000);
		chk(32'h0000_0000, q);
		wb(1'b1, ADR_EIE, 32'h0000_00FF);
		wb(1'b0, ADR_EIE, 32'h0000_0000);
		chk(32'h0000_00B9, q);
		$display("test reset done");
	endtask
	task automatic t_mask();
		wb(1'b1, ADR_EIE, 32'h0000_0000);
		ev(15'h0010);
		wb(1'b0, ADR_PEND, 32'h0000_0000);
		chk(32'h0000_0010, q);
		quiet(4);
		wb(1'b1, ADR_IE, 32'h0000_0010);
		quiet(4);
		wb(1'b1, ADR_IE, 32'h0000_0090);
		take(16'h0023, 1'b0);
		wb(1'b0, ADR_PEND, 32'h0000_0000);
		chk(32'h0000_0010, q);
		return_from_irq_instr <= 1'b1;
		@(posedge clk_i);
		return_from_irq_instr <= 1'b0;
		quiet(3);
		idone <= 1'b1;
		@(posedge clk_i);
		idone <= 1'b0;
		take(16'h0023, 1'b0);
		wb(1'b1, ADR_PEND, 32'h0000_0000);
		ret();
		$display("test mask done");
	endtask
	task automatic t_prio();
		wb(1'b1, ADR_IE, 32'h0000_00FF);
		wb(1'b1, ADR_IP, 32'h0000_0004);
		ev(15'h0007);
		@(posedge clk_i);
		chk(32'h0000_0000, {31'h0, req});
		@(posedge clk_i);
		chk(32'h0000_0001, {31'h0, req});
		take(16'h0013, 1'b1);
		wb(1'b0, ADR_PEND, 32'h0000_0000);
		chk(32'h0000_0003, q);
		quiet(4);
		ret();
		take(16'h0003, 1'b0);
		ev(15'h0004);
		take(16'h0013, 1'b1);
		ret();
		quiet(4);
		ret();
		take(16'h000B, 1'b0);
		ret();
		wb(1'b1, ADR_IP, 32'h0000_0000);
		$display("test priority done");
	endtask
	task automatic t_soft();
		slow <= 1'b1;
		wb(1'b1, ADR_EIE, 32'h0000_00B9);
		for (int i = 0; i < 15; i++)
		begin
			if (SRC_VALID[i])
			begin
				wb(1'b1, ADR_PEND, 32'h1 << i);
				take(16'h0003 + 16'(8 * i), 1'b0);
				wb(1'b1, ADR_PEND, 32'h0000_0000);
				ret();
			end
		end
		slow <= 1'b0;
		$display("test vectors done");
	endtask
	initial
	begin
		repeat (8)
			@(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_mask();
		t_prio();
		t_soft();
		report_and_stop();
	end
	// Tests need a few hundred cycles; ten thousand is ample
	initial
	begin
		#100000;
		fail_count++;
		report_and_stop();
	end
endmodule
